//--- dzs_pkg.sv
package dzs_pkg;

  localparam int unsigned DZS_AW = 4;
  localparam int unsigned DZS_DW = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Register word offsets
  localparam logic [3:0] ADDR_CTRL      = 4'h0;
  localparam logic [3:0] ADDR_SRC       = 4'h1;
  localparam logic [3:0] ADDR_BIAS_NEG  = 4'h2;
  localparam logic [3:0] ADDR_BIAS_POS  = 4'h3;
  localparam logic [3:0] ADDR_RES_PT_A  = 4'h4;
  localparam logic [3:0] ADDR_SRC_PT_A  = 4'h5;
  localparam logic [3:0] ADDR_RES_PT_B  = 4'h6;
  localparam logic [3:0] ADDR_SRC_PT_B  = 4'h7;
  localparam logic [3:0] ADDR_RESULT    = 4'h8;
  localparam logic [3:0] ADDR_FLAGS     = 4'h9;
  localparam logic [3:0] ADDR_IRQ_STAT  = 4'hA;
  localparam logic [3:0] ADDR_IRQ_MASK  = 4'hB;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned CTRL_EXEC_BIT = 0;
  localparam int unsigned CTRL_EDGE_BIT = 1;
  localparam int unsigned CTRL_OP_BIT   = 2;
  localparam int unsigned CTRL_BUSY_BIT = 3;
  localparam int unsigned IRQ_DONE_BIT  = 0;
  localparam int unsigned IRQ_ERR_BIT   = 1;

  // Parameter block index, first word first
  localparam logic [1:0] PAR_RES_A = 2'h0;
  localparam logic [1:0] PAR_SRC_A = 2'h1;
  localparam logic [1:0] PAR_RES_B = 2'h2;
  localparam logic [1:0] PAR_SRC_B = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and arithmetic constants
  localparam logic [15:0] WORD_RST   = 16'h0000;
  localparam logic [1:0]  IRQ_RST    = 2'h0;
  localparam logic [13:0] DEC_MAX    = 14'h270F;
  localparam logic [4:0]  DIV_LAST   = 5'h1F;
  localparam logic [3:0]  DIGIT_MAX  = 4'h9;

  typedef enum logic [1:0] {
    DZS_IDLE = 2'b00,
    DZS_DIV  = 2'b01,
    DZS_FIN  = 2'b11
  } dzs_state_e;

  typedef enum logic {
    DZS_OP_ZONE  = 1'b0,
    DZS_OP_SCALE = 1'b1
  } dzs_op_e;

  typedef struct packed {
    dzs_op_e op;
    logic    edge_mode;
    logic    exec;
  } dzs_ctrl_s;

  typedef struct packed {
    logic er;
    logic gt;
    logic eq;
    logic lt;
    logic neg;
  } dzs_flags_s;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } dzs_bus_s;

  localparam dzs_ctrl_s  CTRL_RST  = '{op: DZS_OP_ZONE, edge_mode: 1'b0, exec: 1'b0};
  localparam dzs_flags_s FLAGS_RST = '{er: 1'b0, gt: 1'b0, eq: 1'b0, lt: 1'b0, neg: 1'b0};

endpackage

//--- dzs_bin2bcd.sv
`timescale 1ns/10ps
module dzs_bin2bcd import dzs_pkg::*; (
  input  wire logic [13:0] bin,
  output logic      [15:0] bcd
);

  logic [29:0] sh;

  // Shift-and-add-three; 9999 fits in four digits so no overflow digit
  always_comb begin
    sh = {16'h0000, bin};
    for (int i = 0; i < 14; i++) begin
      for (int d = 0; d < 4; d++) begin
        if (sh[14 + 4 * d +: 4] > 4'h4) begin
          sh[14 + 4 * d +: 4] = sh[14 + 4 * d +: 4] + 4'h3;
        end
      end
      sh = {sh[28:0], 1'b0};
    end
    bcd = sh[29:14];
  end

endmodule

//--- dzs_datapath.sv
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module dzs_datapath import dzs_pkg::*; (
  input  wire logic     core_clk,
  input  wire logic     rst_n,
  input  wire dzs_bus_s bus,
  output logic [15:0]   rdata,
  output logic          irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic is_bcd(input logic [15:0] w);
    is_bcd = (w[15:12] <= DIGIT_MAX) && (w[11:8] <= DIGIT_MAX) &&
             (w[7:4] <= DIGIT_MAX) && (w[3:0] <= DIGIT_MAX);
  endfunction

  function automatic logic [13:0] bcd_to_bin(input logic [15:0] w);
    bcd_to_bin = 14'(w[15:12]) * 14'h03E8 + 14'(w[11:8]) * 14'h0064 +
                 14'(w[7:4]) * 14'h000A + 14'(w[3:0]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  dzs_ctrl_s   ctrl_r;
  logic [15:0] src_r;
  logic [15:0] bias_neg_r;
  logic [15:0] bias_pos_r;
  logic [15:0] par_r [4];
  logic [15:0] result_r;
  dzs_flags_s  flags_r;
  logic [1:0]  irq_stat_r;
  logic [1:0]  irq_mask_r;
  logic [15:0] rdata_r;

  dzs_state_e  state_r;
  logic        exec_d_r;
  logic        pend_r;
  logic [31:0] dvd_r;
  logic [18:0] rem_r;
  logic [17:0] dvs_r;
  logic [4:0]  cnt_r;
  logic        qneg_r;
  logic [13:0] br_hold_r;

  logic        wr_ctrl;
  logic        wr_stat;
  logic        exec_rise;
  logic        start;
  logic        ev_done;
  logic        ev_err;

  assign wr_ctrl = bus.wr && (bus.addr == ADDR_CTRL);
  assign wr_stat = bus.wr && (bus.addr == ADDR_IRQ_STAT);

  ////////////////////////////////////////////////////////////////////////////
  // Software-written operand and control words

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r     <= CTRL_RST;
      src_r      <= WORD_RST;
      bias_neg_r <= WORD_RST;
      bias_pos_r <= WORD_RST;
      irq_mask_r <= IRQ_RST;
      for (int i = 0; i < 4; i++) begin
        par_r[i] <= WORD_RST;
      end
    end else if (bus.wr) begin
      case (bus.addr)
        ADDR_CTRL: begin
          ctrl_r.exec      <= bus.wdata[CTRL_EXEC_BIT];
          ctrl_r.edge_mode <= bus.wdata[CTRL_EDGE_BIT];
          ctrl_r.op        <= dzs_op_e'(bus.wdata[CTRL_OP_BIT]);
        end
        ADDR_SRC:      src_r      <= bus.wdata;
        ADDR_BIAS_NEG: bias_neg_r <= bus.wdata;
        ADDR_BIAS_POS: bias_pos_r <= bus.wdata;
        ADDR_RES_PT_A, ADDR_SRC_PT_A, ADDR_RES_PT_B, ADDR_SRC_PT_B: begin
          par_r[bus.addr[1:0]] <= bus.wdata;
        end
        ADDR_IRQ_MASK: irq_mask_r <= bus.wdata[1:0];
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Execution condition: level runs every idle cycle, edge mode runs once.
  // A rise seen while a scaling run is busy is held so it is not lost.

  assign exec_rise = ctrl_r.exec && !exec_d_r;
  assign start     = (state_r == DZS_IDLE) &&
                     (ctrl_r.edge_mode ? (pend_r || exec_rise) : ctrl_r.exec);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      exec_d_r <= 1'b0;
      pend_r   <= 1'b0;
    end else begin
      exec_d_r <= ctrl_r.exec;
      pend_r   <= ctrl_r.edge_mode && (pend_r || exec_rise) && !start;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dead-zone arithmetic, one cycle

  logic        src_neg;
  logic        src_zero;
  logic [15:0] dz_res;

  assign src_neg  = src_r[15];
  assign src_zero = (src_r == 16'h0000);

  always_comb begin
    if (src_zero) begin
      dz_res = 16'h0000;
    end else if (src_neg) begin
      dz_res = src_r + bias_neg_r;
    end else begin
      dz_res = src_r + bias_pos_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scaling setup: R = Br - (Br - Ar) * (Bs - S) / (Bs - As)

  logic [13:0]        ar_bin;
  logic [13:0]        br_bin;
  logic               scl_err;
  logic signed [15:0] dy;
  logic signed [16:0] dx;
  logic signed [16:0] ds;
  logic signed [32:0] prod;
  logic [31:0]        prod_mag;
  logic [16:0]        dx_mag;

  assign ar_bin  = bcd_to_bin(par_r[PAR_RES_A]);
  assign br_bin  = bcd_to_bin(par_r[PAR_RES_B]);
  assign scl_err = !is_bcd(par_r[PAR_RES_A]) || !is_bcd(par_r[PAR_RES_B]) ||
                   (par_r[PAR_SRC_A] == par_r[PAR_SRC_B]);
  // Both differences are signed so a reversed pair gives a falling line
  assign dy   = signed'({2'b00, br_bin}) - signed'({2'b00, ar_bin});
  assign dx   = signed'({1'b0, par_r[PAR_SRC_B]}) - signed'({1'b0, par_r[PAR_SRC_A]});
  assign ds   = signed'({1'b0, par_r[PAR_SRC_B]}) - signed'({1'b0, src_r});
  // Widen both factors first so the product is never formed at operand width
  assign prod = 33'(dy) * 33'(ds);
  assign prod_mag = prod[32] ? 32'(-prod) : prod[31:0];
  assign dx_mag   = dx[16] ? 17'(-dx) : 17'(dx);

  ////////////////////////////////////////////////////////////////////////////
  // Restoring divider. Dividend 2|n|+|d| over 2|d| rounds half away from
  // zero; costs 32 cycles instead of a large combinational divider.

  logic [18:0] trial;
  logic        qbit;

  assign trial = {rem_r[17:0], dvd_r[31]};
  assign qbit  = (trial >= {1'b0, dvs_r});

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= DZS_IDLE;
      dvd_r     <= 32'h0000_0000;
      rem_r     <= 19'h0_0000;
      dvs_r     <= 18'h0_0000;
      cnt_r     <= 5'h00;
      qneg_r    <= 1'b0;
      br_hold_r <= 14'h0000;
    end else begin
      case (state_r)
        DZS_IDLE: begin
          if (start && (ctrl_r.op == DZS_OP_SCALE) && !scl_err) begin
            dvd_r     <= {prod_mag[30:0], 1'b0} + {15'h0000, dx_mag};
            dvs_r     <= {dx_mag, 1'b0};
            rem_r     <= 19'h0_0000;
            cnt_r     <= DIV_LAST;
            qneg_r    <= prod[32] ^ dx[16];
            br_hold_r <= br_bin;
            state_r   <= DZS_DIV;
          end
        end
        DZS_DIV: begin
          rem_r <= qbit ? (trial - {1'b0, dvs_r}) : trial;
          dvd_r <= {dvd_r[30:0], qbit};
          cnt_r <= cnt_r - 5'h01;
          if (cnt_r == 5'h00) begin
            state_r <= DZS_FIN;
          end
        end
        DZS_FIN: begin
          state_r <= DZS_IDLE;
        end
        default: begin
          state_r <= DZS_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Final subtraction, clamp and BCD conversion

  logic signed [33:0] r_full;
  logic [13:0]        r_clamp;
  logic [15:0]        r_bcd;

  assign r_full = qneg_r ? (signed'({20'h0_0000, br_hold_r}) + signed'({2'b00, dvd_r}))
                         : (signed'({20'h0_0000, br_hold_r}) - signed'({2'b00, dvd_r}));

  always_comb begin
    if (r_full < 0) begin
      r_clamp = 14'h0000;
    end else if (r_full > signed'({20'h0_0000, DEC_MAX})) begin
      r_clamp = DEC_MAX;
    end else begin
      r_clamp = r_full[13:0];
    end
  end

  dzs_bin2bcd u_bin2bcd (
    .bin (r_clamp),
    .bcd (r_bcd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Result word and condition flags

  assign ev_done = (start && (ctrl_r.op == DZS_OP_ZONE)) || (state_r == DZS_FIN);
  assign ev_err  = start && (ctrl_r.op == DZS_OP_SCALE) && scl_err;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_r <= WORD_RST;
      flags_r  <= FLAGS_RST;
    end else if (start && (ctrl_r.op == DZS_OP_ZONE)) begin
      result_r    <= dz_res;
      flags_r.er  <= 1'b0;
      flags_r.lt  <= src_neg;
      flags_r.gt  <= !src_neg && !src_zero;
      flags_r.eq  <= (dz_res == 16'h0000);
      flags_r.neg <= dz_res[15];
    end else if (ev_err) begin
      // Result word is left untouched when the parameters are unusable
      flags_r.er <= 1'b1;
    end else if (state_r == DZS_FIN) begin
      result_r   <= r_bcd;
      flags_r.er <= 1'b0;
      flags_r.eq <= (r_clamp == 14'h0000);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: write one to clear, a new event wins over the clear

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_r <= IRQ_RST;
    end else begin
      irq_stat_r[IRQ_DONE_BIT] <= ev_done ||
        (irq_stat_r[IRQ_DONE_BIT] && !(wr_stat && bus.wdata[IRQ_DONE_BIT]));
      irq_stat_r[IRQ_ERR_BIT]  <= ev_err ||
        (irq_stat_r[IRQ_ERR_BIT] && !(wr_stat && bus.wdata[IRQ_ERR_BIT]));
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data valid only in the cycle after the strobe

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= WORD_RST;
    end else if (!bus.rd) begin
      rdata_r <= WORD_RST;
    end else begin
      case (bus.addr)
        ADDR_CTRL:     rdata_r <= {12'h000, (state_r != DZS_IDLE), ctrl_r};
        ADDR_SRC:      rdata_r <= src_r;
        ADDR_BIAS_NEG: rdata_r <= bias_neg_r;
        ADDR_BIAS_POS: rdata_r <= bias_pos_r;
        ADDR_RES_PT_A, ADDR_SRC_PT_A, ADDR_RES_PT_B, ADDR_SRC_PT_B: begin
          rdata_r <= par_r[bus.addr[1:0]];
        end
        ADDR_RESULT:   rdata_r <= result_r;
        ADDR_FLAGS:    rdata_r <= {11'h000, flags_r};
        ADDR_IRQ_STAT: rdata_r <= {14'h0000, irq_stat_r};
        ADDR_IRQ_MASK: rdata_r <= {14'h0000, irq_mask_r};
        default:       rdata_r <= WORD_RST;
      endcase
    end
  end

  assign rdata = rdata_r;

endmodule

//--- dzs_datapath_sva.sv
`timescale 1ns/10ps
module dzs_datapath_sva import dzs_pkg::*; (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire dzs_bus_s    bus,
  input wire logic [15:0] rdata,
  input wire logic        irq
);
  logic [15:0] src_h, neg_h, pos_h, res_h, zexp;
  logic [4:0]  zflg;
  logic [2:0]  ctrl_h;
  logic [1:0]  mask_h;
  logic [7:0]  quiet, age;
  logic        rres_q, res_ok, zone_on;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_h  <= WORD_RST;
      neg_h  <= WORD_RST;
      pos_h  <= WORD_RST;
      ctrl_h <= 3'h0;
      mask_h <= IRQ_RST;
    end else if (bus.wr) begin
      if (bus.addr == ADDR_SRC) src_h <= bus.wdata;
      if (bus.addr == ADDR_BIAS_NEG) neg_h <= bus.wdata;
      if (bus.addr == ADDR_BIAS_POS) pos_h <= bus.wdata;
      if (bus.addr == ADDR_CTRL) ctrl_h <= bus.wdata[2:0];
      if (bus.addr == ADDR_IRQ_MASK) mask_h <= bus.wdata[1:0];
    end
  end

  // Ages saturate; 40 cycles outlasts any scaling pass still in flight
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      quiet  <= 8'h00;
      age    <= 8'h00;
      rres_q <= 1'b0;
      res_h  <= WORD_RST;
      res_ok <= 1'b0;
    end else begin
      quiet  <= bus.wr ? 8'h00 : quiet + {7'h0, quiet != 8'hFF};
      age    <= (bus.wr && bus.addr == ADDR_CTRL) ? 8'h00 : age + {7'h0, age != 8'hFF};
      rres_q <= bus.rd && bus.addr == ADDR_RESULT;
      res_h  <= rres_q ? rdata : res_h;
      res_ok <= (bus.wr && bus.addr == ADDR_CTRL) ? 1'b0 :
                rres_q ? (!ctrl_h[0] && age > 8'h28) : res_ok;
    end
  end

  assign zexp    = (src_h == 16'h0000) ? 16'h0000 : src_h + (src_h[15] ? neg_h : pos_h);
  assign zflg    = {1'b0, !src_h[15] && src_h != 16'h0000, zexp == 16'h0000, src_h[15], zexp[15]};
  assign zone_on = ctrl_h == 3'b001 && quiet > 8'h28;

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  rdata_idle_a: assert property (!bus.rd |=> rdata == 16'h0000)
    else $error("read data not zero outside a read answer");
  unmapped_rd_a: assert property (bus.rd && bus.addr > ADDR_IRQ_MASK |=> rdata == 16'h0000)
    else $error("unmapped word read back non-zero");
  param_rb_a:
    assert property (bus.wr && bus.addr inside {[ADDR_SRC:ADDR_SRC_PT_B]} ##1
      bus.rd && bus.addr == $past(bus.addr) |=> rdata == $past(bus.wdata, 2))
    else $error("parameter word did not read back");
  zone_res_a:
    assert property (bus.rd && bus.addr == ADDR_RESULT && zone_on |=> rdata == zexp)
    else $error("dead-zone result differs from prediction");
  zone_flags_a:
    assert property (bus.rd && bus.addr == ADDR_FLAGS && zone_on |=> rdata[4:0] == zflg)
    else $error("dead-zone flags differ from prediction");
  irq_mask_a: assert property (mask_h == 2'h0 |-> !irq)
    else $error("interrupt raised with every source masked");
  irq_stat_a:
    assert property (bus.rd && bus.addr == ADDR_IRQ_STAT |=>
      ((rdata[1:0] & mask_h) != 2'h0) == $past(irq))
    else $error("interrupt level disagrees with masked status");
  result_ro_a: assert property (rres_q && res_ok && !ctrl_h[0] && age > 8'h28 |-> rdata == res_h)
    else $error("result word changed while no operation ran");
endmodule

bind dzs_datapath dzs_datapath_sva i_dzs_datapath_sva (
  .core_clk (core_clk),
  .rst_n    (rst_n),
  .bus      (bus),
  .rdata    (rdata),
  .irq      (irq)
);

//--- dead_zone_and_linear_scaling_test.sv
`timescale 1ns/10ps
module dead_zone_and_linear_scaling_test import dzs_pkg::*;;
  typedef struct packed {
    logic        op;
    logic [15:0] src, a, b, c, d, res;
    logic [4:0]  flg;
  } dzs_row_s;

  logic        core_clk;
  logic        rst_n;
  dzs_bus_s    bus;
  logic [15:0] rdata, d;
  logic        irq;
  int          miscompares, check_count, cycles;
  dzs_row_s    rows [13];

  dzs_datapath i_dzs_datapath (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .bus      (bus),
    .rdata    (rdata),
    .irq      (irq)
  );

  always #12.5 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Writes leave the strobe up so a following access can go back to back
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge core_clk) bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge core_clk) bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk) bus <= '0;
    #1 v = rdata;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk) bus <= '0;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    bus = '0;
    miscompares = 0;
    check_count = 0;
    cycles = 0;
    rows = '{
      '{1'b0, 16'hFFF6, 16'hFF9C, 16'h0064, 16'h0, 16'h0, 16'hFF92, 5'h03},
      '{1'b0, 16'h0000, 16'hFF9C, 16'h0064, 16'h0, 16'h0, 16'h0000, 5'h04},
      '{1'b0, 16'h8000, 16'hFF00, 16'h0064, 16'h0, 16'h0, 16'h7F00, 5'h02},
      '{1'b0, 16'h7FFF, 16'hFF9C, 16'h0001, 16'h0, 16'h0, 16'h8000, 5'h09},
      '{1'b0, 16'h0001, 16'hFF9C, 16'hFFFF, 16'h0, 16'h0, 16'h0000, 5'h0C},
      '{1'b1, 16'h07D0, 16'h0000, 16'h0000, 16'h0300, 16'h0FA0, 16'h0150, 5'h00},
      '{1'b1, 16'hFFFF, 16'h0000, 16'h0000, 16'h0300, 16'h0FA0, 16'h4915, 5'h00},
      '{1'b1, 16'h0002, 16'h0000, 16'h0000, 16'h9999, 16'h0001, 16'h9999, 5'h00},
      '{1'b1, 16'h03E8, 16'h0300, 16'h0000, 16'h0000, 16'h0FA0, 16'h0225, 5'h00},
      '{1'b1, 16'hFFFF, 16'h0300, 16'h0000, 16'h0000, 16'h0FA0, 16'h0000, 5'h04},
      '{1'b1, 16'h0005, 16'h0000, 16'h0000, 16'h0001, 16'h0008, 16'h0001, 5'h00},
      '{1'b1, 16'h0005, 16'h000A, 16'h0000, 16'h0001, 16'h0008, 16'h0001, 5'h10},
      '{1'b1, 16'h0005, 16'h0000, 16'h0008, 16'h0001, 16'h0008, 16'h0001, 5'h10}
    };
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], d);
      check(d, WORD_RST);
    end
    wr(ADDR_IRQ_MASK, 16'h0003);
    foreach (rows[i]) begin
      wr(ADDR_CTRL, {13'h0, rows[i].op, 2'b10});
      wr(ADDR_SRC, rows[i].src);
      if (rows[i].op) begin
        wr(ADDR_RES_PT_A, rows[i].a);
        wr(ADDR_SRC_PT_A, rows[i].b);
        wr(ADDR_RES_PT_B, rows[i].c);
        wr(ADDR_SRC_PT_B, rows[i].d);
      end else begin
        wr(ADDR_BIAS_NEG, rows[i].a);
        wr(ADDR_BIAS_POS, rows[i].b);
      end
      wr(ADDR_CTRL, {13'h0, rows[i].op, 2'b11});
      idle(3);
      d = 16'hFFFF;
      for (int n = 0; n < 40 && d[CTRL_BUSY_BIT] !== 1'b0; n++) rd(ADDR_CTRL, d);
      check(d[CTRL_BUSY_BIT], 1'b0);
      rd(ADDR_RESULT, d);
      check(d, rows[i].res);
      rd(ADDR_FLAGS, d);
      check(d[4:0] & (rows[i].op ? 5'h14 : 5'h1F), rows[i].flg);
    end
    check(irq, 1'b1);
    rd(ADDR_IRQ_STAT, d);
    check(d, 16'h0003);
    wr(ADDR_IRQ_MASK, 16'h0001);
    wr(ADDR_IRQ_STAT, 16'h0001);
    rd(ADDR_IRQ_STAT, d);
    check(d, 16'h0002);
    check(irq, 1'b0);
    // Exec never falls here, so the edge variant must not fire again
    wr(ADDR_CTRL, 16'h0003);
    wr(ADDR_SRC, 16'h0005);
    idle(6);
    rd(ADDR_RESULT, d);
    check(d, 16'h0001);
    wr(ADDR_CTRL, 16'h0001);
    idle(42);
    rd(ADDR_RESULT, d);
    check(d, 16'h0004);
    rd(ADDR_FLAGS, d);
    check(d, 16'h0008);
    check(irq, 1'b1);
    wr(ADDR_IRQ_MASK, 16'h0000);
    wr(ADDR_CTRL, 16'h0000);
    idle(45);
    check(irq, 1'b0);
    rd(ADDR_RESULT, d);
    wr(ADDR_RESULT, 16'h1234);
    wr(4'hC, 16'hFFFF);
    rd(ADDR_RESULT, d);
    check(d, 16'h0004);
    rd(4'hC, d);
    check(d, 16'h0000);
    wr(ADDR_SRC_PT_B, 16'hABCD);
    rd(ADDR_SRC_PT_B, d);
    check(d, 16'hABCD);
    @(posedge core_clk) rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(ADDR_RESULT, d);
    check(d, WORD_RST);
    results();
  end
endmodule
